// ===== pkg/crr_pkg.sv
`default_nettype none
package crr_pkg;
  // ------------------------------------------------------------
  // Register indices; the byte address is the index times four
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_SPEED_CTRL = 8'h02;
  localparam logic [7:0] IDX_CLOCK_LIMITS = 8'h03;
  localparam logic [7:0] IDX_IRQ_EN_PRI = 8'h04;
  localparam logic [7:0] IDX_IRQ_EN_SEC = 8'h05;
  localparam logic [7:0] IDX_VENDOR_HIGH = 8'h06;
  localparam logic [7:0] IDX_IRQ_CTRL = 8'h01;
  localparam logic [7:0] IDX_IRQ_FLAGS_PRI = 8'h10;
  localparam logic [7:0] IDX_IRQ_FLAGS_SEC = 8'h11;
  localparam logic [7:0] IDX_STATUS = 8'h12;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int SPEED_CAP_BIT = 1;
  localparam int IRQ_PULSE_BIT = 5;
  localparam int IRQ_POL_BIT = 4;
  localparam int FW_UPDATE_BIT = 7;
  localparam int SLOT_TWO_LSB = 4;
  localparam int SLOT_ONE_LSB = 0;
  // ------------------------------------------------------------
  // Reset values and write masks
  // ------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] SEC_EN_MASK = 8'h80;
  localparam logic [7:0] PRI_EN_MASK = 8'h7F;
  localparam logic [7:0] IRQ_CTRL_MASK = 8'h30;
  localparam logic [7:0] SPEED_MASK = 8'h02;
  // Built-in vendor code, value arbitrary
  localparam logic [7:0] DEFAULT_VENDOR_HIGH = 8'h5A;
  // ------------------------------------------------------------
  // Clock divider codes and timing
  // ------------------------------------------------------------
  localparam logic [3:0] CODE_DIV_MAX = 4'h7;
  localparam logic [2:0] SHIFT_MAX = 3'h6;
  localparam int CLK_MHZ = 250;
  localparam int IRQ_PULSE_MS = 10;
  localparam int IRQ_PULSE_CYCLES = IRQ_PULSE_MS * CLK_MHZ * 1000;
endpackage
`default_nettype wire

// ===== design/crr_clock_select.sv
`default_nettype none
// ------------------------------------------------------------
// Card clock rate chooser: lower of limit and card maximum
// ------------------------------------------------------------
module crr_clock_select
  import crr_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Limit and card capability
  input wire logic [3:0] limit_code_i,
  input wire logic [2:0] card_shift_i,
  // Chosen divider exponent
  output logic [2:0] shift_o
);
  logic [2:0] limit_shift;
  logic [2:0] shift_next;
  logic [2:0] shift_reg;

  // Code to exponent, undefined codes mean base clock
  function automatic logic [2:0] code_to_shift(input logic [3:0] code);
    if ((code >= 4'h2) && (code <= CODE_DIV_MAX))
      code_to_shift = 3'(code - 4'h1);
    else
      code_to_shift = 3'h0;
  endfunction

  // Slower of the two rates wins
  assign limit_shift = code_to_shift(limit_code_i);
  assign shift_next = (limit_shift > card_shift_i) ? limit_shift : card_shift_i;

  // Output register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      shift_reg <= 3'h0;
    else
      shift_reg <= shift_next;
  end
  assign shift_o = shift_reg;
endmodule
`default_nettype wire

// ===== design/crr_pulse_timer.sv
`default_nettype none
// ------------------------------------------------------------
// Fixed-length pulse timer for the interrupt pulse mode
// ------------------------------------------------------------
module crr_pulse_timer
  import crr_pkg::*;
#(
  parameter int CYCLES = IRQ_PULSE_CYCLES
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Start event
  input wire logic start_i,
  // Pulse active
  output logic active_o
);
  logic [31:0] count_reg;
  logic [31:0] count_next;

  // Reload on start, count down to zero
  assign count_next = start_i ? 32'(CYCLES) :
                      (count_reg != 32'h0) ? count_reg - 32'h1 : 32'h0;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      count_reg <= 32'h0;
    else
      count_reg <= count_next;
  end
  assign active_o = (count_reg != 32'h0);
endmodule
`default_nettype wire

// ===== design/crr_config_regs.sv
// Chosen here: the Wishbone interface to the registers.
`default_nettype none
module crr_config_regs
  import crr_pkg::*;
#(
  parameter int PULSE_CYCLES = IRQ_PULSE_CYCLES
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Event source levels
  input wire logic fullspeed_state_i,
  input wire logic suspend_state_i,
  input wire logic io_supply_state_i,
  input wire logic card_supply_state_i,
  input wire logic bus_power_state_i,
  input wire logic busy_state_i,
  input wire logic slot_one_present_i,
  input wire logic slot_two_present_i,
  input wire logic fw_update_state_i,
  // Reader mode
  input wire logic reader_active_i,
  input wire logic slot_two_selected_i,
  // Card capabilities as divider exponents
  input wire logic [2:0] slot_one_card_shift_i,
  input wire logic [2:0] slot_two_card_shift_i,
  // Controls out
  output logic usb_speed_cap_o,
  output logic [2:0] slot_one_shift_o,
  output logic [2:0] slot_two_shift_o,
  output logic [7:0] vendor_ident_upper_o,
  output logic irq_o
);
  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [7:0] speed_ctrl_reg;
  logic [7:0] irq_ctrl_reg;
  logic [7:0] card_clock_limits_reg;
  logic [7:0] irq_enable_primary_reg;
  logic [7:0] irq_enable_secondary_reg;
  logic [7:0] vendor_ident_high_byte_reg;
  logic vendor_written_reg;
  logic [7:0] flags_pri_reg;
  logic [7:0] flags_sec_reg;
  logic [7:0] flags_pri_next;
  logic [7:0] flags_sec_next;
  logic [7:0] src_pri;
  logic [7:0] src_pri_reg;
  logic src_sec_reg;
  logic [7:0] chg_pri;
  logic chg_sec;
  logic ack_reg;
  logic err_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic card_present;
  logic req;
  logic wr;
  logic rd;
  logic known;
  logic lane0;
  logic clr_pri;
  logic clr_sec;
  logic pending;
  logic pending_reg;
  logic pulse_start;
  logic pulse_active;
  logic irq_level;

  // Byte merge under the low lane strobe
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] mask);
    merge = lane0 ? (wb_dat_i[7:0] & mask) : old;
  endfunction

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  // No new take while an answer is out, so a held strobe is taken every second cycle
  assign req = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
  assign known = (wb_adr_i[7:2] == IDX_SPEED_CTRL[5:0]) ||
                 (wb_adr_i[7:2] == IDX_IRQ_CTRL[5:0]) ||
                 (wb_adr_i[7:2] == IDX_CLOCK_LIMITS[5:0]) ||
                 (wb_adr_i[7:2] == IDX_IRQ_EN_PRI[5:0]) ||
                 (wb_adr_i[7:2] == IDX_IRQ_EN_SEC[5:0]) ||
                 (wb_adr_i[7:2] == IDX_VENDOR_HIGH[5:0]) ||
                 (wb_adr_i[7:2] == IDX_IRQ_FLAGS_PRI[5:0]) ||
                 (wb_adr_i[7:2] == IDX_IRQ_FLAGS_SEC[5:0]) ||
                 (wb_adr_i[7:2] == IDX_STATUS[5:0]);
  assign wr = req && known && wb_we_i;
  assign rd = req && known && !wb_we_i;
  assign lane0 = wb_sel_i[0];
  // A read of a flag register clears it at the take edge
  assign clr_pri = rd && (wb_adr_i[7:2] == IDX_IRQ_FLAGS_PRI[5:0]);
  assign clr_sec = rd && (wb_adr_i[7:2] == IDX_IRQ_FLAGS_SEC[5:0]);

  // Read mux
  always_comb
  begin
    rdata_next = 32'h0;
    unique case (wb_adr_i[7:2])
      IDX_SPEED_CTRL[5:0]: rdata_next[7:0] = speed_ctrl_reg;
      IDX_IRQ_CTRL[5:0]: rdata_next[7:0] = irq_ctrl_reg;
      IDX_CLOCK_LIMITS[5:0]: rdata_next[7:0] = card_clock_limits_reg;
      IDX_IRQ_EN_PRI[5:0]: rdata_next[7:0] = irq_enable_primary_reg;
      IDX_IRQ_EN_SEC[5:0]: rdata_next[7:0] = irq_enable_secondary_reg;
      IDX_VENDOR_HIGH[5:0]: rdata_next[7:0] = vendor_ident_high_byte_reg;
      IDX_IRQ_FLAGS_PRI[5:0]: rdata_next[7:0] = flags_pri_reg;
      IDX_IRQ_FLAGS_SEC[5:0]: rdata_next[7:0] = flags_sec_reg;
      IDX_STATUS[5:0]: rdata_next[7:0] = {6'h0, vendor_written_reg, pending_reg};
      default: rdata_next = 32'h0;
    endcase
  end

  // Bus answer registers
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end
    else
    begin
      ack_reg <= req && known;
      err_reg <= req && !known;
      rdata_reg <= rdata_next;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_err_o = err_reg;
  assign wb_dat_o = rdata_reg;

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      speed_ctrl_reg <= RST_BYTE;
      irq_ctrl_reg <= RST_BYTE;
      card_clock_limits_reg <= RST_BYTE;
      irq_enable_primary_reg <= RST_BYTE;
      irq_enable_secondary_reg <= RST_BYTE;
      vendor_ident_high_byte_reg <= RST_BYTE;
      vendor_written_reg <= 1'b0;
    end
    else if (wr)
    begin
      // Reserved bits are masked on write and always read zero
      if (wb_adr_i[7:2] == IDX_SPEED_CTRL[5:0])
        speed_ctrl_reg <= merge(speed_ctrl_reg, SPEED_MASK);
      if (wb_adr_i[7:2] == IDX_IRQ_CTRL[5:0])
        irq_ctrl_reg <= merge(irq_ctrl_reg, IRQ_CTRL_MASK);
      if (wb_adr_i[7:2] == IDX_CLOCK_LIMITS[5:0])
        card_clock_limits_reg <= merge(card_clock_limits_reg, 8'hFF);
      if (wb_adr_i[7:2] == IDX_IRQ_EN_PRI[5:0])
        irq_enable_primary_reg <= merge(irq_enable_primary_reg, PRI_EN_MASK);
      if (wb_adr_i[7:2] == IDX_IRQ_EN_SEC[5:0])
        irq_enable_secondary_reg <= merge(irq_enable_secondary_reg, SEC_EN_MASK);
      // A write with lane 0 clear does not count as programming
      if ((wb_adr_i[7:2] == IDX_VENDOR_HIGH[5:0]) && lane0)
      begin
        vendor_ident_high_byte_reg <= wb_dat_i[7:0];
        vendor_written_reg <= 1'b1;
      end
    end
  end

  // Speed cap and vendor byte outputs
  assign usb_speed_cap_o = speed_ctrl_reg[SPEED_CAP_BIT];
  assign vendor_ident_upper_o = vendor_written_reg ? vendor_ident_high_byte_reg
                                                   : DEFAULT_VENDOR_HIGH;

  // ------------------------------------------------------------
  // Card clock selection
  // ------------------------------------------------------------
  crr_clock_select u_slot_one
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .limit_code_i(card_clock_limits_reg[SLOT_ONE_LSB +: 4]),
    .card_shift_i(slot_one_card_shift_i),
    .shift_o(slot_one_shift_o)
  );

  crr_clock_select u_slot_two
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .limit_code_i(card_clock_limits_reg[SLOT_TWO_LSB +: 4]),
    .card_shift_i(slot_two_card_shift_i),
    .shift_o(slot_two_shift_o)
  );

  // ------------------------------------------------------------
  // Event sources and change detection
  // ------------------------------------------------------------
  // Card presence follows the selected slot in reader mode
  assign card_present = (reader_active_i && slot_two_selected_i) ? slot_two_present_i
                                                                 : slot_one_present_i;
  // Bit 7 has no source and never flags
  assign src_pri = {1'b0, fullspeed_state_i, suspend_state_i, io_supply_state_i,
                    card_supply_state_i, bus_power_state_i, busy_state_i, card_present};

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      src_pri_reg <= RST_BYTE;
      src_sec_reg <= 1'b0;
    end
    else
    begin
      src_pri_reg <= src_pri;
      src_sec_reg <= fw_update_state_i;
    end
  end
  assign chg_pri = src_pri ^ src_pri_reg;
  assign chg_sec = fw_update_state_i ^ src_sec_reg;

  // Sticky flags; a new change wins over a read clear
  assign flags_pri_next = (clr_pri ? RST_BYTE : flags_pri_reg) | chg_pri;
  assign flags_sec_next = (clr_sec ? RST_BYTE : flags_sec_reg) |
                          {chg_sec, 7'h0};

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      flags_pri_reg <= RST_BYTE;
      flags_sec_reg <= RST_BYTE;
      pending_reg <= 1'b0;
    end
    else
    begin
      flags_pri_reg <= flags_pri_next;
      flags_sec_reg <= flags_sec_next;
      pending_reg <= pending;
    end
  end

  // ------------------------------------------------------------
  // Interrupt output
  // ------------------------------------------------------------
  // Enabled flags only; bits 6..0 of the primary enable, bit 7 of the secondary
  assign pending = |(flags_pri_reg & irq_enable_primary_reg & PRI_EN_MASK) ||
                   (flags_sec_reg[FW_UPDATE_BIT] &&
                    irq_enable_secondary_reg[FW_UPDATE_BIT]);
  // A new pulse only on a fresh rise of the pending level
  assign pulse_start = pending && !pending_reg;

  crr_pulse_timer #(
    .CYCLES(PULSE_CYCLES)
  ) u_pulse
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(pulse_start),
    .active_o(pulse_active)
  );

  // Level or pulse mode, then polarity
  // Pulse mode hides further events until the pending level drops
  assign irq_level = irq_ctrl_reg[IRQ_PULSE_BIT] ? pulse_active : pending_reg;
  assign irq_o = irq_ctrl_reg[IRQ_POL_BIT] ? irq_level : !irq_level;
endmodule
`default_nettype wire

// ===== bench/crr_config_regs_chk.sv
`default_nettype none
module crr_config_regs_chk
  import crr_pkg::*;
#(
  parameter int PULSE_CYCLES = 20
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // Controls
  input wire logic [2:0] slot_one_card_shift_i,
  input wire logic usb_speed_cap_o,
  input wire logic [2:0] slot_one_shift_o,
  input wire logic [7:0] vendor_ident_upper_o
);
  // ------------------------------------------------------------
  // Shadow of written bytes
  // ------------------------------------------------------------
  localparam logic [7:0] RMASK [0:7] = '{8'h00, 8'h30, 8'h02, 8'hFF, 8'h7F, 8'h80, 8'hFF, 8'h00};
  logic [63:0] sh_reg;
  logic vw_reg;
  function automatic logic [2:0] eff(input logic [3:0] c, input logic [2:0] k);
    logic [2:0] d;
    d = (c >= 4'h2 && c <= 4'h7) ? c[2:0] - 3'h1 : 3'h0;
    return (d > k) ? d : k;
  endfunction
  // Request decode
  wire logic [5:0] idx = wb_adr_i[7:2];
  wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire logic mp = wb_adr_i[1:0] == 2'h0 && (idx inside {[6'h01:6'h06], [6'h10:6'h12]});
  wire logic wr = take && mp && wb_we_i && wb_sel_i[0] && idx <= 6'h06;
  wire logic [7:0] rdv = sh_reg[{idx[2:0], 3'h0} +: 8] & RMASK[idx[2:0]];
  wire logic spd = wb_dat_i[1];
  wire logic [2:0] shx = eff(sh_reg[27:24], slot_one_card_shift_i);
  // Shadow update on accepted writes
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sh_reg <= 64'h0;
      vw_reg <= 1'b0;
    end
    else if (wr)
    begin
      sh_reg[{idx[2:0], 3'h0} +: 8] <= wb_dat_i[7:0];
      vw_reg <= vw_reg || idx == 6'h06;
    end
  end
  // Properties
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_take;
    take && mp;
  endsequence
  sequence s_ack;
    wb_ack_o && !wb_err_o ##1 !wb_ack_o;
  endsequence
  property p_ack_once;
    s_take |=> s_ack;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack not one pulse");
  property p_ack_quiet;
    !take |=> !wb_ack_o && !wb_err_o;
  endproperty
  a_ack_quiet: assert property (p_ack_quiet) else $error("answer without request");
  property p_err_unmapped;
    take && !mp |=> wb_err_o && !wb_ack_o && wb_dat_o == 32'h0;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");
  property p_readback;
    take && mp && !wb_we_i && idx <= 6'h05 |=> wb_dat_o == {24'h0, $past(rdv)};
  endproperty
  a_readback: assert property (p_readback) else $error("read data wrong");
  property p_speed;
    wr && idx == 6'h02 |=> usb_speed_cap_o == $past(spd);
  endproperty
  a_speed: assert property (p_speed) else $error("speed cap not written");
  property p_speed_keep;
    !(wr && idx == 6'h02) |=> $stable(usb_speed_cap_o);
  endproperty
  a_speed_keep: assert property (p_speed_keep) else $error("speed cap moved");
  property p_shift;
    $past(rst_n_i) |-> slot_one_shift_o == $past(shx);
  endproperty
  a_shift: assert property (p_shift) else $error("slot one rate wrong");
  property p_vendor;
    vendor_ident_upper_o == (vw_reg ? sh_reg[55:48] : DEFAULT_VENDOR_HIGH);
  endproperty
  a_vendor: assert property (p_vendor) else $error("vendor byte wrong");
endmodule

bind crr_config_regs crr_config_regs_chk #(.PULSE_CYCLES(PULSE_CYCLES)) i_crr_config_regs_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .slot_one_card_shift_i(slot_one_card_shift_i), .usb_speed_cap_o(usb_speed_cap_o),
  .slot_one_shift_o(slot_one_shift_o), .vendor_ident_upper_o(vendor_ident_upper_o)
);
`default_nettype wire

// ===== bench/test_crr_config_regs.sv
`default_nettype none
module test_crr_config_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import crr_pkg::*;
  // ------------------------------------------------------------
  // Stimulus, model and design
  // ------------------------------------------------------------
  localparam int PC = 20;
  logic clk_i = 1'b0, rst_n_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, src = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, rd, r;
  logic s1p = 1'b0, s2s = 1'b1, ra = 1'b1, er;
  logic [2:0] k1 = 3'h0, k2 = 3'h0;
  wire logic [31:0] wb_dat_o;
  wire logic wb_ack_o, wb_err_o, cap, irq;
  wire logic [2:0] sh1, sh2;
  wire logic [7:0] vid;
  int num_errors = 0, n_tests = 0, seed = 23, c, d;
  int m [0:7] = '{default: 0};
  int mk [0:7] = '{8'h00, 8'h30, 8'h02, 8'hFF, 8'h7F, 8'h80, 8'hFF, 8'h00};
  crr_config_regs #(.PULSE_CYCLES(PC)) i_crr_config_regs (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .fullspeed_state_i(src[6]), .suspend_state_i(src[5]), .io_supply_state_i(src[4]),
    .card_supply_state_i(src[3]), .bus_power_state_i(src[2]), .busy_state_i(src[1]),
    .slot_one_present_i(s1p), .slot_two_present_i(src[0]), .fw_update_state_i(src[7]),
    .reader_active_i(ra), .slot_two_selected_i(s2s),
    .slot_one_card_shift_i(k1), .slot_two_card_shift_i(k2),
    .usb_speed_cap_o(cap), .slot_one_shift_o(sh1), .slot_two_shift_o(sh2),
    .vendor_ident_upper_o(vid), .irq_o(irq)
  );
  // Free-running clock
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end
  // Compare, verdict and expected rate
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, x, s);
    end
  endtask
  task automatic end_of_test();
    $display("mismatches %0d of %0d checks", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  function automatic int lm(input int cd, input int k);
    int v;
    v = (cd >= 2 && cd <= 7) ? cd - 1 : 0;
    return (v > k) ? v : k;
  endfunction
  // One classic bus cycle, bounded wait for the answer
  task automatic wb(input logic w, input int a, input int dt, input logic [3:0] s);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= 8'(a);
    wb_sel_i <= s;
    wb_dat_i <= 32'(dt);
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1 || wb_err_o === 1'b1)
        break;
    end
    rd = wb_dat_o;
    er = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n == 20)
    begin
      num_errors++;
      end_of_test();
    end
  endtask
  task automatic wr(input int i, input int v);
    wb(1'b1, i * 4, v, 4'h1);
    m[i] = v & 8'hFF;
  endtask
  task automatic rdk(input int i);
    wb(1'b0, i * 4, 0, 4'h1);
    chk("reg", rd, m[i] & mk[i]);
  endtask
  // Toggle one source, then look at the interrupt line
  task automatic evt(input int b, input logic act);
    @(posedge clk_i);
    if (b > 7)
      s1p <= ~s1p;
    else
      src[b] <= ~src[b];
    repeat (4) @(posedge clk_i);
    chk("irq", irq, act ^ !m[1][4]);
  endtask
  task automatic flags(input int x);
    wb(1'b0, 8'h40, 0, 4'h1);
    chk("flags1", rd, x & 8'h7F);
    wb(1'b0, 8'h44, 0, 4'h1);
    chk("flags2", rd, x & 8'h80);
    repeat (2) @(posedge clk_i);
    chk("irq", irq, !m[1][4]);
  endtask
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    chk("irq", irq, 1);
    chk("vid", vid, DEFAULT_VENDOR_HIGH);
    chk("cap", cap, 0);
    for (c = 1; c < 6; c++)
      rdk(c);
    wb(1'b0, 8'h1C, 0, 4'h1);
    chk("err", er, 1);
    chk("errdat", rd, 0);
    wb(1'b1, 8'h4C, 8'hFF, 4'h1);
    chk("err", er, 1);
    for (c = 0; c < 16; c++)
    begin
      r = $random(seed);
      d = 2 + r[9:8];
      wr(d, d == 5 ? r[7:0] & 8'h80 : r[7:0]);
      rdk(d);
    end
    wb(1'b1, 8'h08, 8'hFF, 4'hE);
    rdk(2);
    chk("cap", cap, m[2][1]);
    for (c = 0; c < 8; c++)
    begin
      wr(4, c < 7 ? 1 << c : 0);
      wr(5, c == 7 ? 8'h80 : 0);
      evt((c + 1) % 8, 0);
      evt(c, 1);
      flags((1 << c) | (1 << ((c + 1) % 8)));
    end
    wr(4, 1);
    wr(5, 0);
    evt(8, 0);
    flags(0);
    evt(8, 0);
    s2s <= 1'b0;
    evt(8, 1);
    flags(1);
    ra <= 1'b0;
    s2s <= 1'b1;
    evt(8, 1);
    flags(1);
    for (c = 0; c < 16; c++)
    begin
      r = $random(seed);
      k1 <= 3'(r[15:0] % 7);
      k2 <= 3'(r[31:16] % 7);
      wr(3, (15 - c) * 16 + c);
      repeat (2) @(posedge clk_i);
      chk("shift1", sh1, lm(c, k1));
      chk("shift2", sh2, lm(15 - c, k2));
    end
    r = $random(seed);
    wr(6, r[7:0]);
    chk("vid", vid, r[7:0]);
    wr(1, 8'h10);
    chk("irq", irq, 0);
    wr(1, 8'h30);
    wr(4, 8'h40);
    evt(6, 1);
    repeat (PC) @(posedge clk_i);
    chk("irq", irq, 0);
    wb(1'b0, 8'h48, 0, 4'h1);
    chk("status", rd, 3);
    end_of_test();
  end
endmodule
`default_nettype wire
